// ### design/serial_eeprom_write_guard.v
`timescale 1ns/100ps
`include "write_guard_defines.vh"

module serial_eeprom_write_guard #(
  parameter integer WRITE_CYCLES = `WRITE_CYCLES
) (
  input  wire        clk_sys_i,         // System clock, 125 MHz.
  input  wire        rst_i,             // Synchronous reset, active high.
  input  wire        sck_i,             // Serial clock pin.
  input  wire        cs_n_i,            // Chip select pin, active low.
  input  wire        si_i,              // Serial data in pin.
  input  wire        wp_n_i,            // Write-guard pin, active low.
  input  wire        part_protected_i,  // Partition table says address guarded.
  input  wire        uv_lockout_i,      // Supply below write threshold.
  input  wire        read_done_i,       // Pulse: an array read finished.
  input  wire        read_corrected_i,  // That read needed correction.
  output reg         so_o,              // Serial data out.
  output reg         so_oe_o,           // Serial out drive enable.
  output reg  [11:0] part_addr_o,       // Address presented to the partition table.
  output reg         nv_start_o,        // Pulse: internal write begins.
  output reg         nv_done_o,         // Pulse: internal write committed.
  output reg  [7:0]  nv_opcode_o,       // Command of the internal write.
  output reg  [7:0]  status_low_o,      // Status byte zero.
  output reg  [7:0]  status_high_o      // Status byte one.
);

  // ==========================================================
  // Pin synchronisers
  reg  [1:0] sck_s_q, cs_s_q, si_s_q, wp_s_q;
  reg        sck_d1_q;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sck_s_q  <= 2'h0;
      cs_s_q   <= 2'h3;
      si_s_q   <= 2'h0;
      wp_s_q   <= 2'h3;
      sck_d1_q <= 1'b0;
    end else begin
      sck_s_q  <= {sck_s_q[0], sck_i};
      cs_s_q   <= {cs_s_q[0], cs_n_i};
      si_s_q   <= {si_s_q[0], si_i};
      wp_s_q   <= {wp_s_q[0], wp_n_i};
      sck_d1_q <= sck_s_q[1];
    end
  end

  // Edges of the serial clock are found on the synchronised copy, two cycles late.
  wire sck_rise = sck_s_q[1] & ~sck_d1_q;
  wire sck_fall = ~sck_s_q[1] & sck_d1_q;
  wire sel      = ~cs_s_q[1];
  wire wp_low   = ~wp_s_q[1];

  // ==========================================================
  // Status state
  reg        pin_guard_enable_q;
  reg  [1:0] block_guard_level_q;
  reg        write_permit_latch_q;
  reg        scheme_select_q;
  reg        correction_used_flag_q;
  reg        config_frozen_flag_q;
  reg        partition_permit_latch_q;
  reg        boundary_lock_flag_q;
  reg        undervoltage_blocked_flag_q;
  reg        busy_q;

  // Both status bytes carry the same busy bit.
  wire [7:0] s0 = {pin_guard_enable_q, 3'h0, block_guard_level_q,
                   write_permit_latch_q, busy_q};
  wire [7:0] s1 = {scheme_select_q, correction_used_flag_q, config_frozen_flag_q,
                   partition_permit_latch_q, boundary_lock_flag_q,
                   undervoltage_blocked_flag_q, 1'b0, busy_q};

  // ==========================================================
  // Frame receiver
  reg        sel_q;
  reg  [6:0] cnt_q;
  reg  [31:0] sh_q;
  reg        wp_low_all_q;
  reg  [7:0] op_q;
  reg  [7:0] cmd_q;

  wire frame_end = sel_q & ~sel;
  // The opcode is caught at the eighth bit, so short frames decode it as well.
  // A frame of fewer than eight bits leaves zero here, which no command uses.
  wire [7:0] opcode = cmd_q;

  // Legacy block guard: level one guards the top quarter, two the top half, three all.
  function guarded_legacy;
    input [1:0]  level;
    input [11:0] addr;
    begin
      case (level)
        2'h0:    guarded_legacy = 1'b0;
        2'h1:    guarded_legacy = (addr >= `LEVEL1_START);
        2'h2:    guarded_legacy = (addr >= `LEVEL2_START);
        default: guarded_legacy = 1'b1;
      endcase
    end
  endfunction

  // Registers guarded only when the pin stayed low for the whole frame.
  wire hw_guard = pin_guard_enable_q & wp_low_all_q;
  wire [11:0] waddr = sh_q[19:8];
  wire arr_guard = scheme_select_q ? part_protected_i
                                   : guarded_legacy(block_guard_level_q, waddr);
  wire both_permits = write_permit_latch_q & partition_permit_latch_q;

  // Commands act once, at select release, and only while no internal write runs.
  reg  [7:0] op_sel;
  reg        start_ok;
  reg        set_permit, clr_permit, set_part, clr_part;
  always @* begin
    op_sel     = opcode;
    start_ok   = 1'b0;
    set_permit = 1'b0;
    clr_permit = 1'b0;
    set_part   = 1'b0;
    clr_part   = 1'b0;
    if (frame_end && !busy_q) begin
      case (op_sel)
        `OP_SET_PERMIT:  set_permit = (cnt_q == 7'h08);
        `OP_CLEAR_PERMIT: clr_permit = 1'b1;
        `OP_SET_PART:    set_part = write_permit_latch_q;
        `OP_CLEAR_PART:  clr_part = 1'b1;
        `OP_SOFT_REINIT: begin
          clr_permit = 1'b1;
          clr_part   = 1'b1;
        end
        `OP_STATUS_WRITE:
          start_ok = write_permit_latch_q & ~hw_guard & (cnt_q >= 7'h10);
        `OP_UV_CFG_WRITE:
          start_ok = write_permit_latch_q & ~hw_guard & (cnt_q >= 7'h10);
        `OP_ARRAY_WRITE:
          start_ok = write_permit_latch_q & ~arr_guard & (cnt_q >= 7'h20);
        `OP_SECURITY_WRITE:
          start_ok = write_permit_latch_q & (cnt_q >= 7'h20);
        `OP_PART_WRITE, `OP_BOUNDARY_GUARD:
          start_ok = both_permits & ~hw_guard & ~config_frozen_flag_q
                     & (cnt_q >= 7'h20);
        `OP_FREEZE:
          start_ok = both_permits & ~hw_guard & ~config_frozen_flag_q
                     & (cnt_q == `FREEZE_BITS)
                     & (sh_q[23:8] == `FREEZE_ADDR)
                     & (sh_q[7:0] == `FREEZE_CONFIRM);
        default: start_ok = 1'b0;
      endcase
    end
  end

  // Bits count only while selected; the shift register keeps the first 32 bits.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_q        <= 1'b0;
      cnt_q        <= 7'h00;
      cmd_q        <= 8'h00;
      sh_q         <= 32'h0000_0000;
      wp_low_all_q <= 1'b0;
    end else begin
      sel_q <= sel;
      if (sel & ~sel_q) begin
        cnt_q        <= 7'h00;
        cmd_q        <= 8'h00;
        wp_low_all_q <= wp_low;
      end else if (sel) begin
        if (!wp_low)
          wp_low_all_q <= 1'b0;
        if (sck_rise) begin
          if (cnt_q == 7'h07)
            cmd_q <= {sh_q[6:0], si_s_q[1]};
          if (cnt_q < 7'h20)
            sh_q <= {sh_q[30:0], si_s_q[1]};
          if (cnt_q != 7'h7f)
            cnt_q <= cnt_q + 7'h01;
        end
      end
    end
  end

  // ==========================================================
  // Internal write sequencer
  reg [23:0] timer_q;
  reg [15:0] data_q;
  reg [6:0]  len_q;
  wire       done = busy_q & (timer_q == 24'h000000);
  // The load value is cut to the timer width on purpose; the count fits easily.
  localparam [31:0] LOAD_VALUE = WRITE_CYCLES - 1;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_q                      <= 1'b0;
      timer_q                     <= 24'h000000;
      op_q                        <= 8'h00;
      data_q                      <= 16'h0000;
      len_q                       <= 7'h00;
      pin_guard_enable_q          <= 1'b0;
      block_guard_level_q         <= `RESET_LEVEL;
      write_permit_latch_q        <= 1'b0;
      scheme_select_q             <= `RESET_SCHEME;
      config_frozen_flag_q        <= 1'b0;
      partition_permit_latch_q    <= 1'b0;
      boundary_lock_flag_q        <= 1'b0;
      undervoltage_blocked_flag_q <= 1'b0;
      correction_used_flag_q      <= 1'b0;
    end else begin
      if (read_done_i)
        correction_used_flag_q <= read_corrected_i;
      if (set_permit)
        write_permit_latch_q <= 1'b1;
      if (clr_permit)
        write_permit_latch_q <= 1'b0;
      if (set_part)
        partition_permit_latch_q <= 1'b1;
      if (clr_part)
        partition_permit_latch_q <= 1'b0;
      // Undervoltage at the start of a write blocks it and is kept until the next start.
      if (start_ok) begin
        undervoltage_blocked_flag_q <= uv_lockout_i;
        if (!uv_lockout_i) begin
          busy_q  <= 1'b1;
          timer_q <= LOAD_VALUE[23:0];
          op_q    <= opcode;
          // A status write of 32 bits keeps its first two data bytes; a 16-bit one keeps its opcode and byte zero.
          if (cnt_q >= 7'h20)
            data_q <= sh_q[23:8];
          else
            data_q <= sh_q[15:0];
          len_q   <= cnt_q;
        end
      end
      // The pin is not looked at here, so a running write always completes.
      if (busy_q && !done)
        timer_q <= timer_q - 24'h000001;
      // On completion the permit drops and the command's own status change is committed.
      if (done) begin
        busy_q               <= 1'b0;
        write_permit_latch_q <= 1'b0;
        case (op_q)
          `OP_STATUS_WRITE: begin
            // Byte zero is the last byte of a two-byte frame, the first of a longer one.
            if (len_q == 7'h10) begin
              block_guard_level_q <= data_q[`S0_LEVEL_HI:`S0_LEVEL_LO];
              if (data_q[`S0_PIN_GUARD] || !wp_low)
                pin_guard_enable_q <= data_q[`S0_PIN_GUARD];
            end else begin
              block_guard_level_q <= data_q[8+`S0_LEVEL_HI:8+`S0_LEVEL_LO];
              if (data_q[8+`S0_PIN_GUARD] || !wp_low)
                pin_guard_enable_q <= data_q[8+`S0_PIN_GUARD];
              if (!config_frozen_flag_q)
                scheme_select_q <= data_q[`S1_SCHEME];
            end
          end
          `OP_BOUNDARY_GUARD:
            boundary_lock_flag_q <= 1'b1;
          `OP_FREEZE: begin
            config_frozen_flag_q     <= 1'b1;
            partition_permit_latch_q <= 1'b0;
          end
          default: config_frozen_flag_q <= config_frozen_flag_q;
        endcase
      end
    end
  end

  // ==========================================================
  // Serial output and registered side outputs
  // Status read and busy poll drive the data line from the first fall after the opcode.
  reg out_rdsr_q, out_poll_q;
  wire [7:0] cur_byte = cnt_q[3] ? s0 : s1;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_rdsr_q    <= 1'b0;
      out_poll_q    <= 1'b0;
      so_o          <= 1'b0;
      so_oe_o       <= 1'b0;
      part_addr_o   <= 12'h000;
      nv_start_o    <= 1'b0;
      nv_done_o     <= 1'b0;
      nv_opcode_o   <= 8'h00;
      status_low_o  <= 8'h00;
      status_high_o <= 8'h00;
    end else begin
      status_low_o  <= s0;
      status_high_o <= s1;
      part_addr_o   <= waddr;
      nv_start_o    <= start_ok & ~uv_lockout_i;
      nv_done_o     <= done;
      nv_opcode_o   <= op_q;
      if (!sel) begin
        out_rdsr_q <= 1'b0;
        out_poll_q <= 1'b0;
        so_oe_o    <= 1'b0;
      end else if (sck_rise && cnt_q == 7'h07) begin
        out_rdsr_q <= ({sh_q[6:0], si_s_q[1]} == `OP_STATUS_READ);
        out_poll_q <= ({sh_q[6:0], si_s_q[1]} == `OP_BUSY_POLL);
      end else if (sck_fall && (out_rdsr_q || out_poll_q)) begin
        so_oe_o <= 1'b1;
        so_o    <= out_poll_q ? busy_q : cur_byte[3'h7 - cnt_q[2:0]];
      end
    end
  end

endmodule // serial_eeprom_write_guard

// ### design/write_guard_defines.vh
// What this block does
// - Legacy scheme: array writes allowed only per the two block-guard level bits.
// - Enhanced scheme follows partition table entries; ignored when legacy is selected.
// - With pin guard on, registers protected only if guard pin low whole frame.
// - Guard pin falling during a running internal write does not stop it, but keeps a status write from clearing pin-guard enable.
// - Pin-guard enable zero makes the guard pin ignored entirely.
// - Freeze leaves pin-guard enable and block-guard level untouched and writable.
// - Freeze ignored while pin-guard enable is one and guard pin low.
// - Freeze is 37h, address AA40h, byte D2h; write starts at select release.
// - Freeze end clears both permits, fixes scheme select, sets frozen flag until reset.
// - Freeze frame shorter than 32 bits aborts with no internal write.
// - Nonvolatile write commands are refused unless the write permit latch is one.
// - Opcode 06h then select release sets write permit at once, no cycle.
// - Write permit clears at reset, nonvolatile write end, clear command, soft reinit.
// - Opcode 04h clears write permit whatever the guard pin does.
// - Byte zero bits 3-2 hold block-guard level; bits 6-4 read zero.
// - Bit 0 of both status bytes is busy during an internal write.
// - Byte one bit 7 selects enhanced when one, legacy (default) when zero.
// - Partition permit in byte one bit 4; partition commands need it set.
// - Boundary-lock flag one is only shown in status; partition writes (32h) are not blocked by it.
// - Byte one bit 2 shows last nonvolatile write blocked by undervoltage.
// - Byte one bit 6 shows the last read needed error correction.
// - Pin-guard enable cannot be cleared while the guard pin is low.
// - Legacy levels: 1 guards 0C00h-0FFFh, 2 guards 0800h-0FFFh, 3 all.
`ifndef WRITE_GUARD_DEFINES_VH
`define WRITE_GUARD_DEFINES_VH

// ==========================================================
// Opcodes
`define OP_STATUS_WRITE   8'h01
`define OP_ARRAY_WRITE    8'h02
`define OP_CLEAR_PERMIT   8'h04
`define OP_STATUS_READ    8'h05
`define OP_SET_PERMIT     8'h06
`define OP_SET_PART       8'h07
`define OP_BUSY_POLL      8'h08
`define OP_CLEAR_PART     8'h0a
`define OP_UV_CFG_WRITE   8'h11
`define OP_PART_WRITE     8'h32
`define OP_BOUNDARY_GUARD 8'h34
`define OP_FREEZE         8'h37
`define OP_SOFT_REINIT    8'h7c
`define OP_SECURITY_WRITE 8'h82

// ==========================================================
// Freeze frame constants
`define FREEZE_ADDR       16'haa40
`define FREEZE_CONFIRM    8'hd2
`define FREEZE_BITS       7'h20

// ==========================================================
// Status field positions
`define S0_PIN_GUARD      7
`define S0_LEVEL_HI       3
`define S0_LEVEL_LO       2
`define S0_PERMIT         1
`define S1_SCHEME         7
`define S1_CORRECTION     6
`define S1_FROZEN         5
`define S1_PART_PERMIT    4
`define S1_BOUNDARY       3
`define S1_UV_BLOCKED     2
`define S_BUSY            0

// ==========================================================
// Legacy guard boundaries and reset values
`define LEVEL1_START      12'hc00
`define LEVEL2_START      12'h800
`define RESET_LEVEL       2'h0
`define RESET_SCHEME      1'b0

// ==========================================================
// Internal write time
`define WRITE_TIME_NS     100000
`define CLK_PERIOD_NS     8
`define WRITE_CYCLES      ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verification/write_guard_sva.sv
`timescale 1ns/100ps
// ========
// Port checker for the write guard.
module write_guard_sva #(
  parameter integer WRITE_CYCLES = 20
) (
  input wire       clk_sys_i,
  input wire       rst_i,
  input wire       read_done_i,
  input wire       read_corrected_i,
  input wire       nv_start_o,
  input wire       nv_done_o,
  input wire [7:0] nv_opcode_o,
  input wire [7:0] status_low_o,
  input wire [7:0] status_high_o
);
  localparam int DLO = WRITE_CYCLES - 1;
  localparam int DHI = WRITE_CYCLES + 2;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  a_busy_both: assert property (status_low_o[0] == status_high_o[0])
    else $error("busy bits differ");
  a_unused_zero: assert property (status_low_o[6:4] == 3'h0 && !status_high_o[1])
    else $error("unused status bits set");
  a_start_busy: assert property (nv_start_o |=> status_low_o[0])
    else $error("no busy after start");
  a_start_done: assert property (nv_start_o |-> ##[DLO:DHI] nv_done_o)
    else $error("write did not finish in time");
  a_start_permit: assert property (nv_start_o |-> status_low_o[1])
    else $error("write started without permit");
  a_freeze_gate: assert property (
    nv_start_o ##1 (nv_opcode_o == 8'h37) |->
      $past(status_low_o[1]) && $past(status_high_o[4]) && !$past(status_high_o[5]))
    else $error("freeze started without both permits");
  a_done_permit: assert property (nv_done_o |-> ##[1:3] !status_low_o[1])
    else $error("permit kept after write");
  a_freeze_end: assert property (
    nv_done_o && nv_opcode_o == 8'h37 |-> ##[1:3] status_high_o[5] && !status_high_o[4])
    else $error("freeze end flags wrong");
  a_frozen_sticks: assert property (
    status_high_o[5] |=> status_high_o[5] && $stable(status_high_o[7]))
    else $error("frozen state changed");
  a_read_flag: assert property (
    read_done_i |-> ##[1:3] status_high_o[6] == read_corrected_i)
    else $error("correction flag wrong");
endmodule // write_guard_sva

bind serial_eeprom_write_guard write_guard_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (
  .clk_sys_i, .rst_i, .read_done_i, .read_corrected_i, .nv_start_o, .nv_done_o,
  .nv_opcode_o, .status_low_o, .status_high_o);

// ### verification/spi_host_model.sv
`timescale 1ns/100ps
// ========
// Host side of the serial link; one frame per call, clock still between frames.
module spi_host_model (
  input  wire         clk_sys_i,  // Pacing clock.
  input  wire         so_i,       // Serial data from the device.
  input  wire         so_oe_i,    // Device drives so_i while high.
  output logic        sck_o,      // Serial clock.
  output logic        cs_n_o,     // Chip select, active low.
  output logic        si_o,       // Serial data to the device.
  output logic [31:0] rx_o        // Bits seen on the data line, newest lowest.
);
  initial begin
    rx_o = 32'h0;
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // Sends the top n bits of d, MSB first, 160 ns per bit.
  task automatic xfer(input logic [31:0] d, input int n);
    cs_n_o <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    for (int i = 31; i > 31 - n; i--) begin
      si_o <= d[i];
      repeat (10) @(posedge clk_sys_i);
      // A released data line floats high, as through a pull-up.
      rx_o <= {rx_o[30:0], so_oe_i ? so_i : 1'b1};
      sck_o <= 1'b1;
      repeat (10) @(posedge clk_sys_i);
      sck_o <= 1'b0;
    end
    repeat (10) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (10) @(posedge clk_sys_i);
  endtask
endmodule // spi_host_model

// ### verification/testbench.sv
`timescale 1ns/100ps
// ========
// Self-checking bench for the write guard.
module testbench;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wp_n_i = 1'b1;
  logic        part_protected_i = 1'b0;
  logic        uv_lockout_i = 1'b0;
  logic        read_done_i = 1'b0;
  logic        read_corrected_i = 1'b0;
  wire         sck_i, cs_n_i, si_i, nv_start_o, nv_done_o, so_o, so_oe_o;
  wire  [7:0]  nv_opcode_o, status_low_o, status_high_o;
  wire  [11:0] part_addr_o;
  wire  [31:0] rx;
  int          error_cnt = 0;
  int          checked = 0;
  logic [31:0] rng = 32'h5e1446fd;
  logic [11:0] ad;
  logic [1:0]  lvl;
  logic        pge, write_permit_latch, scm, correction_used_flag, frz, pp, uvb;

  always #4 clk_sys_i = ~clk_sys_i;

  serial_eeprom_write_guard #(.WRITE_CYCLES(20)) u_dut (
    .clk_sys_i, .rst_i, .sck_i, .cs_n_i, .si_i, .wp_n_i, .part_protected_i,
    .uv_lockout_i, .read_done_i, .read_corrected_i, .so_o, .so_oe_o,
    .part_addr_o, .nv_start_o, .nv_done_o, .nv_opcode_o, .status_low_o,
    .status_high_o);
  spi_host_model u_host (.clk_sys_i, .so_i(so_o), .so_oe_i(so_oe_o), .sck_o(sck_i),
    .cs_n_o(cs_n_i), .si_o(si_i), .rx_o(rx));

  // ========
  // Expectations.
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] s0();
    return {pge, 3'h0, lvl, write_permit_latch, 1'b0};
  endfunction
  function automatic logic [7:0] s1();
    return {scm, correction_used_flag, frz, pp, 1'b0, uvb, 2'h0};
  endfunction
  function automatic logic lg(input logic [1:0] l, input logic [11:0] a);
    return l == 2'h3 || (l == 2'h2 && a >= 12'h800) || (l == 2'h1 && a >= 12'hc00);
  endfunction

  // ========
  // Checking and frame tasks.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(input logic [31:0] d, input int n, input logic st);
    logic s;
    int k;
    s = 1'b0;
    fork
      u_host.xfer(d, n);
      for (k = 0; k < 20 * n + 34; k++) begin
        @(posedge clk_sys_i);
        s |= nv_start_o;
      end
    join
    chk({7'h0, status_high_o[0]}, {7'h0, s});
    for (k = 0; s && !nv_done_o && k < 60; k++) @(posedge clk_sys_i);
    if (k == 60) begin
      error_cnt++;
      complete_run();
    end
    repeat (4) @(posedge clk_sys_i);
    chk({7'h0, s}, {7'h0, st});
    if (s)
      chk({8'h0, nv_opcode_o}, {8'h0, d[31:24]});
    chk(status_low_o, s0());
    chk(status_high_o, s1());
  endtask
  task automatic wen();
    write_permit_latch = 1'b1;
    run(32'h06000000, 8, 1'b0);
  endtask

  // ========
  // Main sequence.
  initial begin
    {pge, write_permit_latch, scm, correction_used_flag, frz, pp, uvb, lvl} = '0;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk(status_low_o, s0());
    chk(status_high_o, s1());
    run(32'h01cc0000, 16, 1'b0);
    wen();
    wp_n_i <= 1'b0;
    write_permit_latch = 1'b0;
    run(32'h04000000, 8, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      wen();
      lvl = i[1:0];
      write_permit_latch = 1'b0;
      run({8'h01, 1'b0, rng[6:4], lvl, rng[1:0], 16'h0}, 16, 1'b1);
      for (int a = 0; a < 4; a++) begin
        ad = 12'h7ff + {a[1], 10'h0} + a[0];
        wen();
        write_permit_latch = lg(lvl, ad);
        run({8'h02, 4'h0, ad, rng[15:8]}, 32, !lg(lvl, ad));
        chk({4'h0, part_addr_o}, {4'h0, ad});
      end
      read_corrected_i <= rng[20];
      read_done_i <= 1'b1;
      @(posedge clk_sys_i);
      read_done_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      correction_used_flag = rng[20];
      chk(status_high_o, s1());
    end
    wen();
    scm = 1'b1;
    write_permit_latch = 1'b0;
    run(32'h010c8000, 24, 1'b1);
    for (int p = 0; p < 2; p++) begin
      part_protected_i <= p[0];
      wen();
      write_permit_latch = p[0];
      run(32'h02fff055, 32, !p[0]);
      chk({4'h0, part_addr_o}, 16'h0ff0);
    end
    part_protected_i <= 1'b0;
    uv_lockout_i <= 1'b1;
    wen();
    uvb = 1'b1;
    run(32'h02001000, 32, 1'b0);
    uv_lockout_i <= 1'b0;
    {uvb, write_permit_latch} = 2'b00;
    run(32'h02001000, 32, 1'b1);
    run(32'h05000000, 24, 1'b0);
    chk(rx[23:8], {8'hff, s0()});
    chk({8'h0, rx[7:0]}, {8'h0, s1()});
    run(32'h08000000, 16, 1'b0);
    chk(rx[15:0], 16'hff00);
    wp_n_i <= 1'b1;
    wen();
    {pge, write_permit_latch} = 2'b10;
    run(32'h018c0000, 16, 1'b1);
    wp_n_i <= 1'b0;
    wen();
    run(32'h010c0000, 16, 1'b0);
    pp = 1'b1;
    run(32'h07000000, 8, 1'b0);
    run(32'h37aa40d2, 32, 1'b0);
    wp_n_i <= 1'b1;
    run(32'h37aa40d2, 31, 1'b0);
    pp = 1'b0;
    run(32'h0a000000, 8, 1'b0);
    run(32'h37aa40d2, 32, 1'b0);
    pp = 1'b1;
    run(32'h07000000, 8, 1'b0);
    {write_permit_latch, pp, frz} = 3'b001;
    fork
      run(32'h37aa40d2, 32, 1'b1);
      begin
        repeat (670) @(posedge clk_sys_i);
        wp_n_i <= 1'b0;
      end
    join
    wen();
    {lvl, write_permit_latch} = 3'b000;
    fork
      run(32'h01000000, 16, 1'b1);
      begin
        repeat (100) @(posedge clk_sys_i);
        wp_n_i <= 1'b1;
        repeat (245) @(posedge clk_sys_i);
        wp_n_i <= 1'b0;
      end
    join
    wp_n_i <= 1'b1;
    wen();
    {pge, lvl, write_permit_latch} = 4'b0010;
    run(32'h01040000, 24, 1'b1);
    wen();
    pp = 1'b1;
    run(32'h07000000, 8, 1'b0);
    run(32'h37aa40d2, 32, 1'b0);
    complete_run();
  end
endmodule // testbench
